/* File: include/srb_consts.svh */
// constants for the shadow register readback unit
// assumes byte-wide legacy i/o writes, one access per clock
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH

// host-visible ports
`define SRB_PORT_INDEX 16'h00f2
`define SRB_PORT_DATA 16'h00f3

// index groups
`define SRB_PAIR_GRP 4'ha
`define SRB_BYTE_BASE 8'hc0
`define SRB_BYTE_LAST 8'hd6
`define SRB_BYTE_CNT 23

// single-byte entry offsets from the byte base
`define SRB_OFS_MODE1 5'h00
`define SRB_OFS_MASK1 5'h04
`define SRB_OFS_MODE2 5'h05
`define SRB_OFS_MASK2 5'h09
`define SRB_OFS_TMR 5'h0a
`define SRB_OFS_PIC1 5'h10
`define SRB_OFS_PIC2 5'h13
`define SRB_OFS_NMI 5'h16

// snooped legacy addresses
`define SRB_IO_DMA1_MODE 16'h000b
`define SRB_IO_DMA1_CLRFF 16'h000c
`define SRB_IO_DMA1_MCLR 16'h000d
`define SRB_IO_DMA1_MASK 16'h000f
`define SRB_IO_DMA2_LO 16'h00c0
`define SRB_IO_DMA2_HI 16'h00ce
`define SRB_IO_DMA2_MODE 16'h00d6
`define SRB_IO_DMA2_CLRFF 16'h00d8
`define SRB_IO_DMA2_MCLR 16'h00da
`define SRB_IO_DMA2_MASK 16'h00de
`define SRB_IO_PIC1_CMD 16'h0020
`define SRB_IO_PIC1_DAT 16'h0021
`define SRB_IO_PIC2_CMD 16'h00a0
`define SRB_IO_PIC2_DAT 16'h00a1
`define SRB_IO_TMR_LO 16'h0040
`define SRB_IO_TMR_HI 16'h0042
`define SRB_IO_TMR_CTL 16'h0043
`define SRB_IO_NMI 16'h0070

// control word fields
`define SRB_ICW1_SEL 4
`define SRB_ICW1_IC4 0
`define SRB_ICW1_SNGL 1
`define SRB_OCW3_SEL 3
`define SRB_TMR_CH_MSB 7
`define SRB_TMR_CH_LSB 6
`define SRB_TMR_RW_MSB 5
`define SRB_TMR_RW_LSB 4

`endif

/* File: include/srb_pkg.sv */
// types shared by the shadow register readback unit
// assumes the consts header supplies all numeric values
package srb_pkg;

  // one i/o cycle as seen on the system side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } srb_io_s;

  // readback answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } srb_rd_s;

  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_ICW2,
    PIC_ICW3,
    PIC_ICW4
  } srb_pic_e;

  // timer access mode: low only, high only, low then high
  typedef logic [1:0] srb_rw_t;

endpackage

/* File: design/srb_pic_seq.sv */
// tracks an interrupt controller init sequence to tag icw2/icw4/ocw3 writes
// assumes cmd_wr and dat_wr are one-cycle strobes, never both in one cycle
`timescale 1ns/1ps
`include "srb_consts.svh"

module srb_pic_seq
  import srb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // snooped writes
  input wire logic cmd_wr,
  input wire logic dat_wr,
  input wire logic [7:0] data,
  // which word the current write is
  output logic icw2_stb,
  output logic icw4_stb,
  output logic ocw3_stb
);

  srb_pic_e state_r;
  srb_pic_e state_nxt;
  logic ic4_r;
  logic sngl_r;
  logic icw1_w;

  assign icw1_w = cmd_wr & data[`SRB_ICW1_SEL];
  assign ocw3_stb = cmd_wr & ~data[`SRB_ICW1_SEL] & data[`SRB_OCW3_SEL];
  assign icw2_stb = dat_wr & (state_r == PIC_ICW2);
  assign icw4_stb = dat_wr & (state_r == PIC_ICW4);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PIC_IDLE: state_nxt = PIC_IDLE;
      PIC_ICW2: if (dat_wr) state_nxt = sngl_r ? (ic4_r ? PIC_ICW4 : PIC_IDLE) : PIC_ICW3;
      PIC_ICW3: if (dat_wr) state_nxt = ic4_r ? PIC_ICW4 : PIC_IDLE;
      PIC_ICW4: if (dat_wr) state_nxt = PIC_IDLE;
      default: state_nxt = PIC_IDLE;
    endcase
    // icw1 restarts the sequence from anywhere
    if (icw1_w) state_nxt = PIC_ICW2;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PIC_IDLE;
      ic4_r <= 1'b0;
      sngl_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (icw1_w) begin
        ic4_r <= data[`SRB_ICW1_IC4];
        sngl_r <= data[`SRB_ICW1_SNGL];
      end
    end
  end

endmodule

/* File: design/srb_top.sv */
// shadow register readback unit: copies of write-only legacy registers
// assumes one i/o access per clock on a synchronous byte-wide bus
// Functional notes
// RQ1: index port selects an entry, data port returns its shadow value.
// RQ2: every defined shadow bit and the index port are readable and writable.
// RQ3: writing a two-byte group index clears the shared byte pointer to low.
// RQ4: first data read gives low byte and moves pointer high; second gives high.
// RQ5: pointer stays high on further reads until the next index write; the code clears it only on a two-byte group index write.
// RQ6: one byte pointer serves every two-byte entry.
// RQ7: host reads two-byte entries as one uninterrupted index-low-high sequence.
// RQ8: dma shadows return values as loaded, never working counts or addresses.
// RQ9: timer shadows return the loaded count, never the live counter.
// RQ10: host masks unused bits of partial entries before restoring them.
// RQ11: dma base and count shadows of channels 0-7 sit at consecutive pair indexes.
// RQ12: single-byte shadows for modes, masks, timer bytes, pic words, nmi mask.
// RQ13: every write to an original legacy address updates its shadow that cycle; the code drops icw1, icw3, ocw1 and ocw2 writes and unshadowed dma ports.
// RQ14: system reset puts the byte pointer on the low byte.
`timescale 1ns/1ps
`include "srb_consts.svh"

module srb_top
  import srb_pkg::*;
#(
  parameter int PAIR_CNT = 16,
  parameter int BYTE_CNT = `SRB_BYTE_CNT,
  parameter int TMR_CNT = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // system i/o cycles, snooped and decoded
  input wire srb_io_s io,
  // readback
  output srb_rd_s rd_ans_r,
  output logic [7:0] index_r,
  output logic byte_ptr_r
);

  function automatic logic is_pair(input logic [7:0] idx);
    is_pair = (idx[7:4] == `SRB_PAIR_GRP);
  endfunction

  function automatic logic is_byte(input logic [7:0] idx);
    is_byte = (idx >= `SRB_BYTE_BASE) && (idx <= `SRB_BYTE_LAST);
  endfunction

  // shadow storage
  logic [15:0] pair_mem [PAIR_CNT];
  logic [7:0] byte_mem [BYTE_CNT];

  // legacy byte flip-flops tracked so captures land in the right half
  logic dma1_ff_r;
  logic dma2_ff_r;
  srb_rw_t tmr_rw_r [TMR_CNT];
  logic tmr_tog_r [TMR_CNT];
  logic tmr_hi_w [TMR_CNT];

  // address decode
  logic wr_index_w;
  logic wr_data_w;
  logic rd_index_w;
  logic rd_data_w;
  logic dma1_w;
  logic dma2_w;
  logic tmr_w;
  logic tmr_ctl_w;
  logic [1:0] tmr_ch_w;
  logic [7:0] ofs_w;

  assign wr_index_w = io.wr && (io.addr == `SRB_PORT_INDEX);
  assign wr_data_w = io.wr && (io.addr == `SRB_PORT_DATA);
  assign rd_index_w = io.rd && (io.addr == `SRB_PORT_INDEX);
  assign rd_data_w = io.rd && (io.addr == `SRB_PORT_DATA);
  assign dma1_w = io.wr && (io.addr[15:3] == 13'h0000);
  assign dma2_w = io.wr && (io.addr >= `SRB_IO_DMA2_LO) && (io.addr <= `SRB_IO_DMA2_HI)
                  && !io.addr[0];
  assign tmr_w = io.wr && (io.addr >= `SRB_IO_TMR_LO) && (io.addr <= `SRB_IO_TMR_HI);
  assign tmr_ctl_w = io.wr && (io.addr == `SRB_IO_TMR_CTL);
  assign tmr_ch_w = io.addr[1:0];
  assign ofs_w = index_r - `SRB_BYTE_BASE;

  // interrupt controller word tagging
  logic p1_icw2_w;
  logic p1_icw4_w;
  logic p1_ocw3_w;
  logic p2_icw2_w;
  logic p2_icw4_w;
  logic p2_ocw3_w;

  srb_pic_seq u_pic1 (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .cmd_wr (io.wr && (io.addr == `SRB_IO_PIC1_CMD)),
    .dat_wr (io.wr && (io.addr == `SRB_IO_PIC1_DAT)),
    .data (io.data),
    .icw2_stb (p1_icw2_w),
    .icw4_stb (p1_icw4_w),
    .ocw3_stb (p1_ocw3_w)
  );

  srb_pic_seq u_pic2 (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .cmd_wr (io.wr && (io.addr == `SRB_IO_PIC2_CMD)),
    .dat_wr (io.wr && (io.addr == `SRB_IO_PIC2_DAT)),
    .data (io.data),
    .icw2_stb (p2_icw2_w),
    .icw4_stb (p2_icw4_w),
    .ocw3_stb (p2_ocw3_w)
  );

  // timer access-mode tracking, one per counter
  genvar g;
  generate
    for (g = 0; g < TMR_CNT; g++) begin : gen_tmr
      logic ctl_hit_w;
      assign ctl_hit_w = tmr_ctl_w
                         && (io.data[`SRB_TMR_CH_MSB:`SRB_TMR_CH_LSB] == 2'(g))
                         && (io.data[`SRB_TMR_RW_MSB:`SRB_TMR_RW_LSB] != 2'h0);
      assign tmr_hi_w[g] = (tmr_rw_r[g] == 2'h2) || ((tmr_rw_r[g] == 2'h3) && tmr_tog_r[g]);
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          tmr_rw_r[g] <= 2'h3;
          tmr_tog_r[g] <= 1'b0;
        end else if (ctl_hit_w) begin
          tmr_rw_r[g] <= io.data[`SRB_TMR_RW_MSB:`SRB_TMR_RW_LSB];
          tmr_tog_r[g] <= 1'b0;
        end else if (tmr_w && (tmr_ch_w == 2'(g)) && (tmr_rw_r[g] == 2'h3)) begin
          tmr_tog_r[g] <= ~tmr_tog_r[g];
        end
      end
    end
  endgenerate

  // pair store: dma base/count as loaded, or restore through the data port
  logic p_we_w;
  logic [3:0] p_idx_w;
  logic p_hi_w;

  assign p_we_w = dma1_w || dma2_w || (wr_data_w && is_pair(index_r));  // [RQ2] [RQ13]
  assign p_idx_w = dma1_w ? {1'b0, io.addr[2:0]} :                       // [RQ11]
                   dma2_w ? {1'b1, io.addr[3:1]} : index_r[3:0];          // [RQ11]
  assign p_hi_w = dma1_w ? dma1_ff_r : dma2_w ? dma2_ff_r : byte_ptr_r;

  // single-byte store
  logic b_we_w;
  logic [4:0] b_ofs_w;
  logic mode1_w;
  logic mode2_w;
  logic mask1_w;
  logic mask2_w;
  logic nmi_w;
  logic pic_w;

  assign mode1_w = io.wr && (io.addr == `SRB_IO_DMA1_MODE);
  assign mode2_w = io.wr && (io.addr == `SRB_IO_DMA2_MODE);
  assign mask1_w = io.wr && (io.addr == `SRB_IO_DMA1_MASK);
  assign mask2_w = io.wr && (io.addr == `SRB_IO_DMA2_MASK);
  assign nmi_w = io.wr && (io.addr == `SRB_IO_NMI);
  assign pic_w = p1_icw2_w || p1_icw4_w || p1_ocw3_w || p2_icw2_w || p2_icw4_w || p2_ocw3_w;
  // [RQ12] [RQ13] each snooped write lands in its own byte entry
  assign b_we_w = mode1_w || mode2_w || mask1_w || mask2_w || nmi_w || pic_w || tmr_w
                  || (wr_data_w && is_byte(index_r));                     // [RQ2]
  assign b_ofs_w =
    mode1_w ? `SRB_OFS_MODE1 + {3'h0, io.data[1:0]} :                     // [RQ8]
    mode2_w ? `SRB_OFS_MODE2 + {3'h0, io.data[1:0]} :                     // [RQ8]
    mask1_w ? `SRB_OFS_MASK1 :
    mask2_w ? `SRB_OFS_MASK2 :
    nmi_w ? `SRB_OFS_NMI :
    tmr_w ? `SRB_OFS_TMR + {2'h0, tmr_ch_w, 1'b0} + {4'h0, tmr_hi_w[tmr_ch_w]} :  // [RQ9]
    p1_icw2_w ? `SRB_OFS_PIC1 :
    p1_icw4_w ? `SRB_OFS_PIC1 + 5'h01 :
    p1_ocw3_w ? `SRB_OFS_PIC1 + 5'h02 :
    p2_icw2_w ? `SRB_OFS_PIC2 :
    p2_icw4_w ? `SRB_OFS_PIC2 + 5'h01 :
    p2_ocw3_w ? `SRB_OFS_PIC2 + 5'h02 : ofs_w[4:0];

  // readback select; undefined indexes read zero
  logic [15:0] pair_sel_w;
  logic [7:0] data_rd_w;
  logic [7:0] rdata_w;

  assign pair_sel_w = pair_mem[index_r[3:0]];
  assign data_rd_w = is_pair(index_r) ? (byte_ptr_r ? pair_sel_w[15:8] : pair_sel_w[7:0]) :  // [RQ4]
                     is_byte(index_r) ? byte_mem[ofs_w[4:0]] : 8'h00;                       // [RQ1]
  assign rdata_w = rd_index_w ? index_r : data_rd_w;                                         // [RQ2]

  // one pointer for all pairs; index write wins over a same-cycle data access
  logic ptr_nxt;
  assign ptr_nxt = (wr_index_w && is_pair(io.data)) ? 1'b0 :                   // [RQ3] [RQ6]
                   ((rd_data_w || wr_data_w) && is_pair(index_r)) ? 1'b1 :      // [RQ4] [RQ5]
                   byte_ptr_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      index_r <= 8'h00;
      byte_ptr_r <= 1'b0;                                                      // [RQ14]
      rd_ans_r <= '0;
    end else begin
      byte_ptr_r <= ptr_nxt;
      if (wr_index_w) index_r <= io.data;                                      // [RQ1]
      rd_ans_r.valid <= rd_index_w || rd_data_w;
      rd_ans_r.data <= (rd_index_w || rd_data_w) ? rdata_w : 8'h00;
    end
  end

  // dma byte flip-flops follow the controllers' own sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma1_ff_r <= 1'b0;
      dma2_ff_r <= 1'b0;
    end else begin
      if (io.wr && (io.addr == `SRB_IO_DMA1_CLRFF || io.addr == `SRB_IO_DMA1_MCLR)) begin
        dma1_ff_r <= 1'b0;
      end else if (dma1_w) begin
        dma1_ff_r <= ~dma1_ff_r;
      end
      if (io.wr && (io.addr == `SRB_IO_DMA2_CLRFF || io.addr == `SRB_IO_DMA2_MCLR)) begin
        dma2_ff_r <= 1'b0;
      end else if (dma2_w) begin
        dma2_ff_r <= ~dma2_ff_r;
      end
    end
  end

  // shadow arrays; cleared at reset so a readback is never unknown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PAIR_CNT; i++) pair_mem[i] <= 16'h0000;
    end else if (p_we_w) begin
      if (p_hi_w) pair_mem[p_idx_w][15:8] <= io.data;                         // [RQ8]
      else pair_mem[p_idx_w][7:0] <= io.data;                                 // [RQ8]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BYTE_CNT; i++) byte_mem[i] <= 8'h00;
    end else if (b_we_w) begin
      byte_mem[b_ofs_w] <= io.data;                                           // [RQ13]
    end
  end

endmodule

/* File: dv/srb_top_sva.sv */
// checker for the readback unit: answer timing, index and byte pointer
// assumes one clock domain and the top module's ports only
`timescale 1ns/1ps
`include "srb_consts.svh"
module srb_top_sva
  import srb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched ports
  input wire srb_io_s io,
  input wire srb_rd_s rd_ans_r,
  input wire logic [7:0] index_r,
  input wire logic byte_ptr_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire hit_index = io.addr == `SRB_PORT_INDEX;
  wire hit_data = io.addr == `SRB_PORT_DATA;
  wire port_acc = (io.rd || io.wr) && (hit_index || hit_data);
  wire port_rd = io.rd && (hit_index || hit_data);
  wire pair_wr = io.wr && hit_index && io.data[7:4] == `SRB_PAIR_GRP;
  wire pair_sel = index_r[7:4] == `SRB_PAIR_GRP;
  ans_due_a: assert property (port_rd |=> rd_ans_r.valid)
    else $error("read of a port got no answer");
  ans_none_a: assert property (!port_rd |=> !rd_ans_r.valid)
    else $error("answer without a port read");
  idx_read_a: assert property (io.rd && hit_index |=> rd_ans_r.data == $past(index_r))
    else $error("index readback differs");
  idx_write_a: assert property (io.wr && hit_index |=> index_r == $past(io.data))
    else $error("index write lost");
  ptr_clear_a: assert property (pair_wr |=> !byte_ptr_r)
    else $error("pointer not cleared");
  ptr_step_a: assert property (port_acc && hit_data && pair_sel |=> byte_ptr_r)
    else $error("pointer did not move high");
  ptr_hold_a: assert property (byte_ptr_r && !pair_wr |=> byte_ptr_r)
    else $error("pointer left high byte");
  ptr_still_a: assert property (!port_acc |=> $stable(byte_ptr_r))
    else $error("pointer moved without port access");
  // the host leaves one idle cycle between accesses, so the pointer rises three edges on
  pair_cov_c: cover property (pair_wr ##3 byte_ptr_r);
  high_cov_c: cover property (byte_ptr_r && io.rd && hit_data);
  idx_cov_c: cover property (io.rd && hit_index);
endmodule

bind srb_top srb_top_sva u_srb_top_sva (.clk_sys(clk_sys), .rst_n(rst_n), .io(io),
  .rd_ans_r(rd_ans_r), .index_r(index_r), .byte_ptr_r(byte_ptr_r));

/* File: dv/srb_host.sv */
// host model: byte-wide i/o reads and writes toward the readback unit
// assumes strobes change at the falling edge, answer one cycle later
`timescale 1ns/1ps
`include "srb_consts.svh"
module srb_host
  import srb_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // i/o bus
  output srb_io_s io,
  input wire srb_rd_s rd_ans_r
);
  initial io = '0;
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic v);
    @(negedge clk_sys);
    io.wr = w;
    io.rd = !w;
    io.addr = a;
    io.data = d;
    @(negedge clk_sys);
    q = rd_ans_r.data;
    v = rd_ans_r.valid;
    io.wr = 1'b0;
    io.rd = 1'b0;
    // released data must not keep its old value
    io.data = ~d;
  endtask
  // caller keeps interrupts off; index, low, high unbroken
  task automatic pair_rd(input logic [7:0] idx, output logic [15:0] val);
    logic v;
    acc(1'b1, `SRB_PORT_INDEX, idx, val[7:0], v);
    acc(1'b0, `SRB_PORT_DATA, 8'h00, val[7:0], v);
    acc(1'b0, `SRB_PORT_DATA, 8'h00, val[15:8], v);
  endtask
  // unused bits read undefined, so they are dropped on restore
  task automatic pair_wr(input logic [7:0] idx, input logic [15:0] val,
      input logic [15:0] msk);
    logic [7:0] q;
    logic v;
    acc(1'b1, `SRB_PORT_INDEX, idx, q, v);
    acc(1'b1, `SRB_PORT_DATA, val[7:0] & msk[7:0], q, v);
    acc(1'b1, `SRB_PORT_DATA, val[15:8] & msk[15:8], q, v);
  endtask
endmodule

/* File: dv/shadow_register_readback_bench.sv */
// bench for the readback unit: snooped writes, index and data ports
// assumes srb_host makes every i/o cycle
`timescale 1ns/1ps
`include "srb_consts.svh"
module shadow_register_readback_bench
  import srb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  srb_io_s io;
  srb_rd_s rd_ans_r;
  logic [7:0] index_r;
  logic byte_ptr_r;
  logic [15:0] w16;
  // second controller: single, no icw4, so the extra data write must not land
  // timer ch1 high-only and ch2 low-only exercise the other access modes
  logic [23:0] snp [23] = '{24'h004330, 24'h004012, 24'h004034, 24'h00708f,
    24'h000b46, 24'h000f05, 24'h002011, 24'h002108, 24'h002104, 24'h002101,
    24'h00200a, 24'h00d6c1, 24'h00a012, 24'h00a170, 24'h00a155, 24'h00de0f,
    24'h00d800, 24'h00c0ab, 24'h00c0cd, 24'h004360, 24'h00419a, 24'h004390,
    24'h00425c};
  logic [15:0] ent [16] = '{16'hca12, 16'hcb34, 16'hd68f, 16'hc246, 16'hc405,
    16'hd008, 16'hd101, 16'hd20a, 16'hc6c1, 16'hd370, 16'hd400, 16'hc90f,
    16'ha8ab, 16'hcd9a, 16'hce5c, 16'hb000};
  always #20 clk_sys = ~clk_sys;
  srb_top u_srb_top (.clk_sys(clk_sys), .rst_n(rst_n), .io(io), .rd_ans_r(rd_ans_r),
    .index_r(index_r), .byte_ptr_r(byte_ptr_r));
  srb_host u_srb_host (.clk_sys(clk_sys), .io(io), .rd_ans_r(rd_ans_r));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value, time %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    u_srb_host.acc(1'b1, a, d, q, v);
  endtask
  // exp[8] is the expected valid flag
  task automatic rd(input logic [15:0] a, input logic [8:0] exp);
    logic [7:0] q;
    logic v;
    u_srb_host.acc(1'b0, a, 8'h00, q, v);
    chk({7'h00, v}, {7'h00, exp[8]});
    chk(q, exp[7:0]);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("wrong value, time %0t: run too long", $time);
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, byte_ptr_r}, 8'h00);
    rst_n = 1'b1;
    // dma ch0 base through the byte flip-flop
    wr(16'h000c, 8'h00);
    wr(16'h0000, 8'h34);
    wr(16'h0000, 8'h12);
    wr(`SRB_PORT_INDEX, 8'ha0);
    chk({7'h00, byte_ptr_r}, 8'h00);
    rd(`SRB_PORT_DATA, 9'h134);
    rd(`SRB_PORT_DATA, 9'h112);
    rd(`SRB_PORT_DATA, 9'h112);
    wr(`SRB_PORT_INDEX, 8'hd6);
    chk({7'h00, byte_ptr_r}, 8'h01);
    wr(`SRB_PORT_INDEX, 8'ha5);
    chk({7'h00, byte_ptr_r}, 8'h00);
    foreach (snp[i]) wr(snp[i][23:8], snp[i][7:0]);
    foreach (ent[i]) begin
      wr(`SRB_PORT_INDEX, ent[i][15:8]);
      chk(index_r, ent[i][15:8]);
      rd(`SRB_PORT_INDEX, {1'b1, ent[i][15:8]});
      rd(`SRB_PORT_DATA, {1'b1, ent[i][7:0]});
    end
    u_srb_host.pair_wr(8'ha2, 16'h5678, 16'hffff);
    u_srb_host.pair_rd(8'ha2, w16);
    chk(w16[7:0], 8'h78);
    chk(w16[15:8], 8'h56);
    // mid-run reset with the pointer high must bring it back to the low byte
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk({7'h00, byte_ptr_r}, 8'h00);
    chk(index_r, 8'h00);
    rst_n = 1'b1;
    rd(16'h0021, 9'h000);
    test_done();
  end
endmodule
